/* File: shared/rtc_pkg.sv */
// Package of constants and types for the time-of-day clock block.
// Assumes a 25 MHz system clock and a sampled 32.768 kHz crystal input.
package rtc_pkg;
    // ------------------------------------------------------------
    // Register locations
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_SEC = 8'h00;
    localparam logic [7:0] ADDR_SEC_ALM = 8'h01;
    localparam logic [7:0] ADDR_MIN = 8'h02;
    localparam logic [7:0] ADDR_MIN_ALM = 8'h03;
    localparam logic [7:0] ADDR_HOUR = 8'h04;
    localparam logic [7:0] ADDR_HOUR_ALM = 8'h05;
    localparam logic [7:0] ADDR_DOW = 8'h06;
    localparam logic [7:0] ADDR_DATE = 8'h07;
    localparam logic [7:0] ADDR_MONTH = 8'h08;
    localparam logic [7:0] ADDR_YEAR = 8'h09;
    localparam logic [7:0] ADDR_CTL_A = 8'h0a;
    localparam logic [7:0] ADDR_CTL_B = 8'h0b;
    localparam logic [7:0] ADDR_FLAGS = 8'h0c;
    localparam logic [7:0] ADDR_VALID = 8'h0d;
    localparam logic [7:0] ADDR_GP_FIRST = 8'h0e;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int A_UIP = 7;
    localparam int B_SET = 7;
    localparam int B_PIE = 6;
    localparam int B_AIE = 5;
    localparam int B_UIE = 4;
    localparam int B_BIN = 2;
    localparam int B_H24 = 1;
    localparam int C_IRQ_SUMMARY_FLAG = 7;
    localparam int C_PF = 6;
    localparam int C_AF = 5;
    localparam int C_UF = 4;
    localparam int D_VRT = 7;
    // ------------------------------------------------------------
    // Reset values and codes
    // ------------------------------------------------------------
    localparam logic [7:0] CTL_A_WMASK = 8'h7f;
    localparam logic [7:0] CTL_B_WMASK = 8'hf6;
    localparam logic [2:0] DIV_NORMAL = 3'h2;
    localparam logic [7:0] SHARED_CTL_RST = 8'h80;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] WILD_MASK = 8'hc0;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int XTAL_HZ = 32768;
    localparam int PEND_US = 244;
    localparam int UPD_US = 1948;
    // Crystal ticks, rounded: lead time is a least time, update a longest time.
    localparam int PEND_TICKS = (PEND_US * XTAL_HZ + 999999) / 1000000;
    localparam int UPD_TICKS = (UPD_US * XTAL_HZ) / 1000000;
    localparam int HALF_SEC_TICKS = XTAL_HZ / 2;
    localparam logic [14:0] SEC_WRAP = 15'h7fff;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_PEND = 2'b01,
        ST_UPD = 2'b10
    } rtc_upd_t;

    typedef struct packed {
        logic [7:0] sec;
        logic [7:0] min;
        logic [7:0] hour;
        logic [7:0] dow;
        logic [7:0] date;
        logic [7:0] month;
        logic [7:0] year;
    } rtc_time_t;
endpackage

/* File: verilog/rtc_core.sv */
// Time-of-day clock with calendar, alarm and CMOS storage behind an index/data port pair.
// Assumes the crystal and battery-low inputs come from outside the clock domain.
//
// Summary of operation
// [R01] System reset keeps storage, and keeps time and calendar when the battery is good.
// [R02] Reset with battery clears enables and flags.
// [R03] Reset blocks register access, floats interrupt.
// [R04] Reset with dead battery zeroes 0-12.
// [R05] Interrupt high while flag and enable set.
// [R06] Route interrupt only with nonzero select; polarity.
// [R07] Locations: time, alarms, control, then storage.
// [R08] Certain control bits and locations are read-only.
// [R09] Count and compare in binary or BCD.
// [R10] Twelve-hour mode uses top bit as PM.
// [R11] Inhibit bit aborts and blocks updates.
// [R12] Software sets inhibit while loading time.
// [R13] Software reloads hours after format change.
// [R14] One update per second when enabled.
// [R15] Carry through calendar with month ends, leaps.
// [R16] Alarm flag when all alarm bytes match.
// [R17] Top two bits set make a wildcard.
// [R18] Time reads during update are undefined.
// [R19] Pending flag leads update by 244 us.
// [R20] Time base is the 32.768 kHz crystal.
// [R21] Index port selects, data port transfers.
// [R22] Reading the flag register clears flags.
// [R23] First update half second after divider release.
// [R24] Update strobe comes from a binary divider.
// [R25] Writes leave read-only and status bits.
module rtc_core #(
    parameter int GP_DEPTH = 242
) (
    // Clock, enable and reset
    input wire logic clk_sys,
    input wire logic clk_en,
    input wire logic rst_n,
    // System side
    input wire logic system_reset_input,
    input wire logic battery_low,
    input wire logic crystal_in_pin,
    // Index and data port pair
    input wire logic idx_wr,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data,
    // Interrupt routing
    input wire logic [3:0] irq_select,
    input wire logic irq8_invert,
    output logic clock_irq_pin,
    output logic clock_irq_oe,
    output logic irq8_out
);
    // ------------------------------------------------------------
    // Crystal sampling and tick
    // ------------------------------------------------------------
    logic [2:0] xtal_sync_ff;
    logic xtal_state_ff;
    logic xtal_tick;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            xtal_sync_ff <= 3'h0;
            xtal_state_ff <= 1'b0;
        end else if (clk_en) begin
            xtal_sync_ff <= {xtal_sync_ff[1:0], crystal_in_pin};
            if (xtal_sync_ff[1] == xtal_sync_ff[2]) begin
                xtal_state_ff <= xtal_sync_ff[2];
            end
        end
    end
    // A rising crystal edge once the second and third stages agree.
    assign xtal_tick = clk_en && (xtal_sync_ff[1] == xtal_sync_ff[2])
        && xtal_sync_ff[2] && !xtal_state_ff; // [R20]

    logic [2:0] sres_sync_ff;
    logic [2:0] batt_sync_ff;
    logic sres_ff;
    logic batt_low_ff;
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sres_sync_ff <= 3'h0;
            batt_sync_ff <= 3'h0;
            sres_ff <= 1'b0;
            batt_low_ff <= 1'b0;
        end else if (clk_en) begin
            sres_sync_ff <= {sres_sync_ff[1:0], system_reset_input};
            batt_sync_ff <= {batt_sync_ff[1:0], battery_low};
            if (sres_sync_ff[1] == sres_sync_ff[2]) begin
                sres_ff <= sres_sync_ff[2];
            end
            if (batt_sync_ff[1] == batt_sync_ff[2]) begin
                batt_low_ff <= batt_sync_ff[2];
            end
        end
    end
    logic sres_good;
    logic sres_dead;
    assign sres_good = sres_ff && !batt_low_ff;
    assign sres_dead = sres_ff && batt_low_ff;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    rtc_pkg::rtc_time_t time_ff;
    logic [7:0] sec_alm_ff;
    logic [7:0] min_alm_ff;
    logic [7:0] hour_alm_ff;
    logic [7:0] ctl_a_ff;
    logic [7:0] ctl_b_ff;
    logic [7:0] flags_ff;
    logic [7:0] index_ff;
    logic [7:0] gp_mem [GP_DEPTH];
    rtc_pkg::rtc_upd_t upd_ff;
    logic [14:0] div_ff;
    logic [11:0] phase_ff;

    logic access_ok;
    logic wr_hit;
    logic rd_flags;
    assign access_ok = !sres_ff; // [R03] [R04]
    assign wr_hit = data_wr && access_ok && clk_en; // [R21]
    assign rd_flags = data_rd && access_ok && clk_en && (index_ff == rtc_pkg::ADDR_FLAGS);

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            index_ff <= rtc_pkg::ZERO_BYTE;
        end else if (clk_en && idx_wr && access_ok) begin
            index_ff <= wr_data; // [R21]
        end
    end

    // ------------------------------------------------------------
    // BCD or binary arithmetic helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] to_bin(input logic [7:0] v, input logic bin);
        to_bin = bin ? v : 8'((v[7:4] * 4'ha) + {4'h0, v[3:0]}); // [R09]
    endfunction
    function automatic logic [7:0] from_bin(input logic [7:0] v, input logic bin);
        logic [7:0] t;
        t = v / 8'h0a;
        from_bin = bin ? v : {t[3:0], 4'((v - 8'(t * 8'h0a)))}; // [R09]
    endfunction
    function automatic logic [7:0] month_len(input logic [7:0] m, input logic [7:0] y);
        case (m)
            8'h02: month_len = (y[1:0] == 2'h0) ? 8'h1d : 8'h1c;
            8'h04, 8'h06, 8'h09, 8'h0b: month_len = 8'h1e;
            default: month_len = 8'h1f;
        endcase
    endfunction
    function automatic logic alarm_hit(input logic [7:0] alm, input logic [7:0] cur);
        alarm_hit = ((alm & rtc_pkg::WILD_MASK) == rtc_pkg::WILD_MASK) || (alm == cur); // [R17]
    endfunction

    // ------------------------------------------------------------
    // One-second advance
    // ------------------------------------------------------------
    logic bin;
    logic h24;
    rtc_pkg::rtc_time_t nxt_time;
    logic [7:0] b_sec, b_min, b_hr, b_dow, b_date, b_mon, b_yr;
    logic pm;
    assign bin = ctl_b_ff[rtc_pkg::B_BIN];
    assign h24 = ctl_b_ff[rtc_pkg::B_H24];
    always_comb begin
        b_sec = to_bin(time_ff.sec, bin);
        b_min = to_bin(time_ff.min, bin);
        pm = time_ff.hour[7] && !h24; // [R10]
        b_hr = to_bin({1'b0, time_ff.hour[6:0]}, bin);
        b_dow = time_ff.dow;
        b_date = to_bin(time_ff.date, bin);
        b_mon = to_bin(time_ff.month, bin);
        b_yr = to_bin(time_ff.year, bin);
        if (b_sec >= 8'h3b) begin // [R15]
            b_sec = 8'h00;
            if (b_min >= 8'h3b) begin
                b_min = 8'h00;
                if (h24 ? (b_hr >= 8'h17) : (b_hr == 8'h0b && pm)) begin // [R10]
                    b_hr = h24 ? 8'h00 : 8'h0c;
                    pm = 1'b0;
                    b_dow = (b_dow >= 8'h07) ? 8'h01 : 8'(b_dow + 8'h01);
                    if (b_date >= month_len(b_mon, b_yr)) begin // [R15]
                        b_date = 8'h01;
                        if (b_mon >= 8'h0c) begin
                            b_mon = 8'h01;
                            b_yr = (b_yr >= 8'h63) ? 8'h00 : 8'(b_yr + 8'h01);
                        end else begin
                            b_mon = 8'(b_mon + 8'h01);
                        end
                    end else begin
                        b_date = 8'(b_date + 8'h01);
                    end
                end else if (!h24 && b_hr == 8'h0b) begin
                    b_hr = 8'h0c;
                    pm = 1'b1;
                end else if (!h24 && b_hr == 8'h0c) begin
                    b_hr = 8'h01;
                end else begin
                    b_hr = 8'(b_hr + 8'h01);
                end
            end else begin
                b_min = 8'(b_min + 8'h01);
            end
        end else begin
            b_sec = 8'(b_sec + 8'h01);
        end
        nxt_time.sec = from_bin(b_sec, bin);
        nxt_time.min = from_bin(b_min, bin);
        nxt_time.hour = from_bin(b_hr, bin) | {pm, 7'h00};
        nxt_time.dow = b_dow;
        nxt_time.date = from_bin(b_date, bin);
        nxt_time.month = from_bin(b_mon, bin);
        nxt_time.year = from_bin(b_yr, bin);
    end

    // ------------------------------------------------------------
    // Divider chain and update sequencer
    // ------------------------------------------------------------
    logic div_run;
    logic inhibit;
    logic sec_strobe;
    logic upd_done;
    assign div_run = (ctl_a_ff[6:4] == rtc_pkg::DIV_NORMAL);
    assign inhibit = ctl_b_ff[rtc_pkg::B_SET];
    // The divider restarts at its midpoint, so the first strobe lands half a second on.
    assign sec_strobe = xtal_tick && div_run && (div_ff == rtc_pkg::SEC_WRAP); // [R24] [R23]
    assign upd_done = xtal_tick && (upd_ff == rtc_pkg::ST_UPD)
        && (phase_ff == 12'(rtc_pkg::UPD_TICKS - 1));

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            div_ff <= 15'(rtc_pkg::HALF_SEC_TICKS);
        end else if (clk_en && !div_run) begin
            div_ff <= 15'(rtc_pkg::HALF_SEC_TICKS); // [R23]
        end else if (xtal_tick) begin
            div_ff <= 15'(div_ff + 15'h1); // [R24]
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            upd_ff <= rtc_pkg::ST_IDLE;
            phase_ff <= 12'h0;
        end else if (clk_en && (inhibit || !div_run)) begin
            upd_ff <= rtc_pkg::ST_IDLE; // [R11] [R14]
            phase_ff <= 12'h0;
        end else if (xtal_tick) begin
            case (upd_ff)
                rtc_pkg::ST_IDLE: begin
                    if (div_ff == 15'(rtc_pkg::SEC_WRAP - 15'(rtc_pkg::PEND_TICKS))) begin
                        upd_ff <= rtc_pkg::ST_PEND; // [R19]
                    end
                end
                rtc_pkg::ST_PEND: begin
                    if (sec_strobe) begin
                        upd_ff <= rtc_pkg::ST_UPD; // [R14]
                        phase_ff <= 12'h0;
                    end
                end
                rtc_pkg::ST_UPD: begin
                    phase_ff <= 12'(phase_ff + 12'h1);
                    if (upd_done) begin
                        upd_ff <= rtc_pkg::ST_IDLE;
                    end
                end
                default: upd_ff <= rtc_pkg::ST_IDLE;
            endcase
        end
    end
    logic advance;
    assign advance = sec_strobe && (upd_ff == rtc_pkg::ST_PEND) && !inhibit;

    // ------------------------------------------------------------
    // Time, alarm and storage registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        // System reset with a good battery leaves these alone.
        if (!rst_n) begin
            time_ff <= '0;
            sec_alm_ff <= rtc_pkg::ZERO_BYTE;
            min_alm_ff <= rtc_pkg::ZERO_BYTE;
            hour_alm_ff <= rtc_pkg::ZERO_BYTE;
        end else if (clk_en && sres_dead) begin
            time_ff <= '0; // [R04]
            sec_alm_ff <= rtc_pkg::ZERO_BYTE;
            min_alm_ff <= rtc_pkg::ZERO_BYTE;
            hour_alm_ff <= rtc_pkg::ZERO_BYTE;
        end else if (advance) begin
            time_ff <= nxt_time; // [R15] [R01]
        end else if (wr_hit) begin // [R07]
            if (index_ff == rtc_pkg::ADDR_SEC) begin
                time_ff.sec <= wr_data;
            end else if (index_ff == rtc_pkg::ADDR_SEC_ALM) begin
                sec_alm_ff <= wr_data;
            end else if (index_ff == rtc_pkg::ADDR_MIN) begin
                time_ff.min <= wr_data;
            end else if (index_ff == rtc_pkg::ADDR_MIN_ALM) begin
                min_alm_ff <= wr_data;
            end else if (index_ff == rtc_pkg::ADDR_HOUR) begin
                time_ff.hour <= wr_data;
            end else if (index_ff == rtc_pkg::ADDR_HOUR_ALM) begin
                hour_alm_ff <= wr_data;
            end else if (index_ff == rtc_pkg::ADDR_DOW) begin
                time_ff.dow <= wr_data;
            end else if (index_ff == rtc_pkg::ADDR_DATE) begin
                time_ff.date <= wr_data;
            end else if (index_ff == rtc_pkg::ADDR_MONTH) begin
                time_ff.month <= wr_data;
            end else if (index_ff == rtc_pkg::ADDR_YEAR) begin
                time_ff.year <= wr_data;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (wr_hit && index_ff >= rtc_pkg::ADDR_GP_FIRST) begin
            gp_mem[8'(index_ff - rtc_pkg::ADDR_GP_FIRST)] <= wr_data; // [R01] [R07]
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctl_a_ff <= rtc_pkg::ZERO_BYTE;
            ctl_b_ff <= rtc_pkg::ZERO_BYTE;
        end else if (clk_en && sres_dead) begin
            ctl_a_ff <= rtc_pkg::ZERO_BYTE; // [R04]
            ctl_b_ff <= rtc_pkg::ZERO_BYTE;
        end else if (clk_en && sres_good) begin
            ctl_b_ff[rtc_pkg::B_PIE] <= 1'b0; // [R02]
            ctl_b_ff[rtc_pkg::B_AIE] <= 1'b0;
            ctl_b_ff[rtc_pkg::B_UIE] <= 1'b0;
        end else if (wr_hit && index_ff == rtc_pkg::ADDR_CTL_A) begin
            ctl_a_ff <= wr_data & rtc_pkg::CTL_A_WMASK; // [R08] [R25]
        end else if (wr_hit && index_ff == rtc_pkg::ADDR_CTL_B) begin
            ctl_b_ff <= wr_data & rtc_pkg::CTL_B_WMASK; // [R08] [R25]
            if (wr_data[rtc_pkg::B_SET]) begin
                ctl_b_ff[rtc_pkg::B_UIE] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt flags
    // ------------------------------------------------------------
    logic alarm_now;
    logic [2:0] flag_set;
    assign alarm_now = alarm_hit(sec_alm_ff, nxt_time.sec)
        && alarm_hit(min_alm_ff, nxt_time.min)
        && alarm_hit(hour_alm_ff, nxt_time.hour); // [R16]
    // The periodic tap is outside this block; that flag is never raised here.
    assign flag_set = {1'b0, advance && alarm_now, upd_done};
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            flags_ff <= rtc_pkg::ZERO_BYTE;
        end else if (clk_en && sres_ff) begin
            flags_ff <= rtc_pkg::ZERO_BYTE; // [R02] [R04]
        end else if (clk_en) begin
            // A new event wins over a read in the same cycle.
            flags_ff[rtc_pkg::C_PF] <= flag_set[2] | (flags_ff[rtc_pkg::C_PF] & !rd_flags);
            flags_ff[rtc_pkg::C_AF] <= flag_set[1] | (flags_ff[rtc_pkg::C_AF] & !rd_flags);
            flags_ff[rtc_pkg::C_UF] <= flag_set[0] | (flags_ff[rtc_pkg::C_UF] & !rd_flags); // [R22]
        end
    end
    logic irq_any;
    assign irq_any = |(flags_ff[6:4] & ctl_b_ff[6:4]); // [R05]

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rd_data <= rtc_pkg::ZERO_BYTE;
        end else if (clk_en && data_rd) begin
            if (!access_ok) begin
                rd_data <= rtc_pkg::ZERO_BYTE; // [R03]
            end else if (index_ff == rtc_pkg::ADDR_SEC) begin
                rd_data <= time_ff.sec; // [R18]
            end else if (index_ff == rtc_pkg::ADDR_SEC_ALM) begin
                rd_data <= sec_alm_ff;
            end else if (index_ff == rtc_pkg::ADDR_MIN) begin
                rd_data <= time_ff.min;
            end else if (index_ff == rtc_pkg::ADDR_MIN_ALM) begin
                rd_data <= min_alm_ff;
            end else if (index_ff == rtc_pkg::ADDR_HOUR) begin
                rd_data <= time_ff.hour;
            end else if (index_ff == rtc_pkg::ADDR_HOUR_ALM) begin
                rd_data <= hour_alm_ff;
            end else if (index_ff == rtc_pkg::ADDR_DOW) begin
                rd_data <= time_ff.dow;
            end else if (index_ff == rtc_pkg::ADDR_DATE) begin
                rd_data <= time_ff.date;
            end else if (index_ff == rtc_pkg::ADDR_MONTH) begin
                rd_data <= time_ff.month;
            end else if (index_ff == rtc_pkg::ADDR_YEAR) begin
                rd_data <= time_ff.year;
            end else if (index_ff == rtc_pkg::ADDR_CTL_A) begin
                rd_data <= {upd_ff != rtc_pkg::ST_IDLE, ctl_a_ff[6:0]}; // [R19] [R25]
            end else if (index_ff == rtc_pkg::ADDR_CTL_B) begin
                rd_data <= ctl_b_ff;
            end else if (index_ff == rtc_pkg::ADDR_FLAGS) begin
                rd_data <= {irq_any, flags_ff[6:0]};
            end else if (index_ff == rtc_pkg::ADDR_VALID) begin
                rd_data <= {!batt_low_ff, 7'h00};
            end else begin
                rd_data <= gp_mem[8'(index_ff - rtc_pkg::ADDR_GP_FIRST)];
            end
        end
    end

    // ------------------------------------------------------------
    // Interrupt pin
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            clock_irq_pin <= 1'b0;
            clock_irq_oe <= 1'b0;
            irq8_out <= 1'b0;
        end else if (clk_en) begin
            clock_irq_pin <= irq_any; // [R05]
            clock_irq_oe <= !sres_ff && (irq_select != 4'h0); // [R03] [R06]
            irq8_out <= (irq_select == 4'h8) && (irq_any ^ irq8_invert); // [R06]
        end
    end
endmodule

/* File: tb/rtc_host_model.sv */
// Host port and crystal model for the clock block.
// Assumes the bench calls xfer and supplies clk_sys.
module rtc_host_model (
    // Clock
    input wire logic clk_sys,
    // Port pair and crystal
    output logic idx_wr,
    output logic data_wr,
    output logic data_rd,
    output logic [7:0] wr_data,
    output logic crystal_in_pin,
    input wire logic [7:0] rd_data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {idx_wr, data_wr, data_rd, crystal_in_pin, wr_data} = 12'h000;
        forever begin
            repeat (2) @(negedge clk_sys);
            crystal_in_pin = ~crystal_in_pin;
        end
    end
    task automatic xfer(input logic [7:0] ad, input logic w, input logic [7:0] d,
            output logic [7:0] q);
        @(negedge clk_sys);
        {idx_wr, wr_data} = {1'b1, ad};
        @(negedge clk_sys);
        {idx_wr, data_wr, data_rd, wr_data} = {1'b0, w, ~w, d};
        @(negedge clk_sys);
        {data_wr, data_rd, wr_data} = {2'b00, ~d};
        q = rd_data;
    endtask
endmodule

/* File: tb/rtc_core_chk.sv */
// Port checks for the clock block.
// Assumes one clock domain; bound below.
module rtc_core_chk (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Watched ports
    input wire logic system_reset_input,
    input wire logic idx_wr,
    input wire logic data_rd,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] rd_data,
    input wire logic [3:0] irq_select,
    input wire logic irq8_invert,
    input wire logic clock_irq_pin,
    input wire logic clock_irq_oe,
    input wire logic irq8_out
);
    logic [7:0] idx_ff;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    always_ff @(posedge clk_sys) begin
        if (!rst_n) idx_ff <= 8'h00;
        else if (idx_wr) idx_ff <= wr_data;
    end
    sequence s_in_rst;
        system_reset_input [*6];
    endsequence
    sequence s_flag_rd;
        data_rd && idx_ff == rtc_pkg::ADDR_FLAGS;
    endsequence
    a_oe_unrouted: assert property ((irq_select == 4'h0) [*2] |-> !clock_irq_oe)
        else $error("pin driven while unrouted");
    a_irq8_idle: assert property ((irq_select != 4'h8) [*2] |-> !irq8_out)
        else $error("line eight active while not chosen");
    a_irq8_polarity: assert property ((irq_select == 4'h8 && $stable(irq8_invert)
        && $stable(clock_irq_pin)) [*2] |-> irq8_out == (clock_irq_pin ^ irq8_invert))
        else $error("line eight polarity wrong");
    a_rst_floats: assert property (s_in_rst |-> !clock_irq_oe)
        else $error("pin driven in system reset");
    a_rst_drops_irq: assert property (s_in_rst |=> !clock_irq_pin)
        else $error("interrupt kept in system reset");
    a_rst_refuses: assert property (s_in_rst ##0 data_rd |=> rd_data == 8'h00)
        else $error("read answered in system reset");
    a_flag_rd_clears: assert property (s_flag_rd |-> ##[1:4] !clock_irq_pin)
        else $error("flag read left interrupt up");
    a_rd_data_holds: assert property (!data_rd |=> $stable(rd_data))
        else $error("read data changed without read");
endmodule
bind rtc_core rtc_core_chk i_rtc_core_chk (.clk_sys, .rst_n, .system_reset_input, .idx_wr,
    .data_rd, .wr_data, .rd_data, .irq_select, .irq8_invert, .clock_irq_pin, .clock_irq_oe,
    .irq8_out);

/* File: tb/testbench.sv */
// Self-checking bench with a register model, an update run and system resets.
// Assumes the host model drives the port pair and the crystal.
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys, rst_n, system_reset_input, battery_low, irq8_invert;
    logic idx_wr, data_wr, data_rd, crystal_in_pin, clock_irq_pin, clock_irq_oe, irq8_out;
    logic [3:0] irq_select;
    logic [7:0] wr_data, rd_data, q, a;
    logic [7:0] mdl [int];
    logic [7:0] tv [10] = '{8'h59, 8'hc0, 8'h59, 8'hc0, 8'h23, 8'hc0, 8'h07, 8'h28, 8'h02, 8'h04};
    logic [7:0] tn [10] = '{8'h00, 8'hc0, 8'h00, 8'hc0, 8'h00, 8'hc0, 8'h01, 8'h29, 8'h02, 8'h04};
    logic [31:0] seed = 32'h0444;
    int errors = 0;
    int n_compared = 0;
    int t;
    rtc_core i_rtc_core (.clk_sys, .clk_en(1'b1), .rst_n, .system_reset_input, .battery_low,
        .crystal_in_pin, .idx_wr, .data_wr, .data_rd, .wr_data, .rd_data, .irq_select,
        .irq8_invert, .clock_irq_pin, .clock_irq_oe, .irq8_out);
    rtc_host_model i_rtc_host_model (.clk_sys, .idx_wr, .data_wr, .data_rd, .wr_data,
        .crystal_in_pin, .rd_data);
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] r;
        r = s ^ (s << 13);
        r = r ^ (r >> 17);
        return r ^ (r << 5);
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        i_rtc_host_model.xfer(ad, 1'b1, d, q);
        if (ad == 8'h0a) mdl[ad] = d & 8'h7f;
        else if (ad == 8'h0b) mdl[ad] = d & 8'hf6;
        else if (ad != 8'h0c && ad != 8'h0d) mdl[ad] = d;
    endtask
    task automatic rd(input logic [7:0] ad, input logic [7:0] e);
        i_rtc_host_model.xfer(ad, 1'b0, 8'h00, q);
        check($sformatf("location %h", ad), q, e);
    endtask
    task automatic finish_test;
        $display("compared %0d errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        {rst_n, system_reset_input, battery_low, irq8_invert, irq_select} = 8'h00;
        mdl[12] = 8'h00;
        mdl[13] = 8'h80;
        repeat (6) @(negedge clk_sys);
        rst_n = 1'b1;
        for (int i = 0; i < 3; i++) begin
            seed = xs(seed);
            a = (i == 0) ? 8'h0e : (i == 1) ? 8'hff : {1'b1, seed[14:8]};
            wr(a, seed[7:0]);
        end
        wr(8'h0c, 8'hff);
        wr(8'h0d, 8'h00);
        wr(8'h0a, 8'hff);
        wr(8'h0b, 8'h37);
        foreach (mdl[k]) rd(k[7:0], mdl[k]);
        wr(8'h0b, 8'ha2);
        foreach (tv[i]) wr(i[7:0], tv[i]);
        wr(8'h0b, 8'h22);
        {irq_select, irq8_invert} = {4'h8, seed[0]};
        wr(8'h0a, 8'h20);
        t = 0;
        while (clock_irq_pin !== 1'b1 && t < 70000) begin
            @(negedge clk_sys);
            t++;
        end
        check("first update delay", 8'(t > 65400 && t < 65800), 8'h01);
        if (t >= 70000) finish_test();
        check("irq8 level", {7'h00, irq8_out}, {7'h00, ~irq8_invert});
        check("irq enable", {7'h00, clock_irq_oe}, 8'h01);
        repeat (400) @(negedge clk_sys);
        foreach (tn[i]) mdl[i] = tn[i];
        mdl[12] = 8'hb0;
        for (int i = 0; i < 13; i++) rd(i[7:0], mdl[i]);
        @(negedge clk_sys);
        check("irq level", {7'h00, clock_irq_pin}, 8'h00);
        system_reset_input = 1'b1;
        repeat (6) @(negedge clk_sys);
        i_rtc_host_model.xfer(8'h0e, 1'b1, 8'h00, q);
        rd(8'h0e, 8'h00);
        system_reset_input = 1'b0;
        repeat (6) @(negedge clk_sys);
        {mdl[11], mdl[12]} = 16'h0200;
        foreach (mdl[k]) rd(k[7:0], mdl[k]);
        {system_reset_input, battery_low} = 2'b11;
        repeat (8) @(negedge clk_sys);
        {system_reset_input, battery_low} = 2'b00;
        repeat (6) @(negedge clk_sys);
        for (int i = 0; i < 13; i++) rd(i[7:0], 8'h00);
        rd(8'h0d, 8'h80);
        rd(8'h0e, mdl[14]);
        finish_test();
    end
endmodule
